// File: verilog/tfe_error_flags.sv
`timescale 1ns/10ps
// Contract
// - Late write clock on write sets timing error
// - Transfer while bus occupied sets timing error
// - Timing error raises end-of-block, exception, abort
// - Late clock implies frame count advanced
// - Reads raise timing error only for occupied
// - Write on protected transport sets nonexec
// - Reverse command at tape start sets nonexec
// - Density versus capability mismatch sets nonexec
// - Space/write with frame status zero: nonexec
// - Short frame count low density sets nonexec
// - PE excessive correctable skew sets skew flag
// - Bad NRZ filemark pattern sets flag
// - Bad filemark also raises tape mark status
// - Space ending with nonzero count sets error
// - Run held after end-of-block sets error
// - Characters in early gap set gap flag
// - PE bad preamble/postamble sets format flag
// - NRZ LRC mismatch sets check flag
// - PE uncorrectable conditions set data flag
// - NRZ parity or late data sets flag
// - Flags hold until initialize or drive clear
module tfe_error_flags (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_drive_clear,
    input wire logic i_bus_init,
    input wire logic i_cmd_start,
    input wire logic i_cmd_write,
    input wire logic i_cmd_read,
    input wire logic i_cmd_space,
    input wire logic i_cmd_reverse,
    input wire logic i_xfer_start,
    input wire logic i_space_end,
    input wire logic i_xfer_end,
    input wire logic i_char_due,
    input wire logic i_wclk,
    input wire logic i_bus_occupied,
    input wire logic i_run,
    input wire logic i_write_protect,
    input wire logic i_bot,
    input wire logic i_pe_capable,
    input wire logic [15:0] i_fc_load,
    input wire logic i_fc_load_en,
    input wire logic i_frame_step,
    input wire logic i_rd_char,
    input wire logic [7:0] i_rd_data,
    input wire logic i_blank_char,
    input wire logic i_gap_first_half,
    input wire logic i_pe_skew_warn,
    input wire logic i_pe_bad_amble,
    input wire logic i_lrc_valid,
    input wire logic [7:0] i_lrc_tape,
    input wire logic i_pe_multi_dead,
    input wire logic i_pe_parity_nodead,
    input wire logic i_pe_skew_ovf,
    input wire logic i_nrz_parity_err,
    input wire logic i_nrz_late_data,
    output logic o_end_of_block,
    output logic o_exception,
    output logic o_abort,
    output logic o_tape_mark,
    output logic [15:0] o_frame_count
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] err_r, err_nxt, ctrl_r, fc_r, rdata_r;
    logic eob_r, tm_r, wclk_s1_r, wclk_s2_r, wclk_d_r, wait_clk_r;
    logic [7:0] lrc_r;
    logic [2:0] blank_r;
    logic [7:0] fm_char_r;
    typedef enum logic [1:0] {
        FM_IDLE = 2'b00,
        FM_BLANKS = 2'b01,
        FM_SECOND = 2'b10
    } tfe_fm_state_t;
    tfe_fm_state_t fm_st_r;
    logic gap_char_r;
    logic fc_moved_r;
    wire clr = i_bus_init | i_drive_clear;
    wire den2 = ctrl_r[tfe_pkg::CTRL_DEN2];
    wire frame_count_status_bit = ctrl_r[tfe_pkg::CTRL_FCS];
    wire wclk_rise = wclk_s2_r & ~wclk_d_r;
    // Write clock must arrive before the character slot closes
    // Only armed once a frame has gone out, so the count tells both cases apart
    wire late_wclk = i_cmd_write & wait_clk_r & i_char_due & ~wclk_rise & fc_moved_r;
    wire occ_err = i_xfer_start & i_bus_occupied;
    wire dte_set = late_wclk | occ_err;
    wire [15:0] fc_neg = 16'h0000 - fc_r;
    wire nef_protect = i_cmd_write & i_write_protect;
    wire nef_bot = i_cmd_reverse & i_bot;
    wire nef_density = (den2 != i_pe_capable);
    wire nef_no_fcs = (i_cmd_space | i_cmd_write) & ~frame_count_status_bit;
    // Low density needs at least the minimum record length
    wire nef_short = (i_cmd_read | i_cmd_write) & ~den2 & (fc_neg < tfe_pkg::MIN_FRAMES);
    wire nef_set = i_cmd_start & (nef_protect | nef_bot | nef_density | nef_no_fcs | nef_short);
    // Second single character after the blank run decides the filemark
    wire fm_done = (fm_st_r == FM_SECOND) & i_rd_char & ~den2;
    wire fm_bad = fm_done & ((i_rd_data != tfe_pkg::FM_CHAR) | (fm_char_r != tfe_pkg::FM_CHAR));
    wire fce_set = (i_space_end & (fc_r != 16'h0000)) | (eob_r & i_run);
    wire nsg_set = i_xfer_end & (gap_char_r | (i_rd_char & i_gap_first_half));
    wire fmt_set = den2 ? i_pe_bad_amble : (i_lrc_valid & (i_lrc_tape != lrc_r));
    wire inc_set = i_cmd_read & (den2 ? (i_pe_multi_dead | i_pe_parity_nodead | i_pe_skew_ovf)
        : (i_nrz_parity_err | i_nrz_late_data));
    wire skew_set = (den2 & i_pe_skew_warn) | fm_bad;
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        err_nxt = err_r;
        if (clr) begin
            err_nxt = tfe_pkg::ERR_RESET;
        end
        err_nxt[tfe_pkg::BIT_DTE] = err_nxt[tfe_pkg::BIT_DTE] | dte_set;
        err_nxt[tfe_pkg::BIT_NEF] = err_nxt[tfe_pkg::BIT_NEF] | nef_set;
        err_nxt[tfe_pkg::BIT_SKEW] = err_nxt[tfe_pkg::BIT_SKEW] | skew_set;
        err_nxt[tfe_pkg::BIT_FCE] = err_nxt[tfe_pkg::BIT_FCE] | fce_set;
        err_nxt[tfe_pkg::BIT_NSG] = err_nxt[tfe_pkg::BIT_NSG] | nsg_set;
        err_nxt[tfe_pkg::BIT_FMT] = err_nxt[tfe_pkg::BIT_FMT] | fmt_set;
        err_nxt[tfe_pkg::BIT_INC] = err_nxt[tfe_pkg::BIT_INC] | inc_set;
    end
    // Flag register has no write path at all
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            err_r <= tfe_pkg::ERR_RESET;
        end else begin
            err_r <= err_nxt;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_r <= tfe_pkg::CTRL_RESET;
        end else if (i_wr && i_addr == tfe_pkg::ADDR_CTRL) begin
            ctrl_r <= i_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write clock comes from the far side, so resynchronise first
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wclk_s1_r <= 1'b0;
            wclk_s2_r <= 1'b0;
            wclk_d_r <= 1'b0;
        end else begin
            wclk_s1_r <= i_wclk;
            wclk_s2_r <= wclk_s1_r;
            wclk_d_r <= wclk_s2_r;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_clk_r <= 1'b0;
        end else if (i_xfer_start || i_char_due) begin
            wait_clk_r <= i_cmd_write;
        end else if (wclk_rise) begin
            wait_clk_r <= 1'b0;
        end
    end
    // Frame counter advances per frame; the moved bit separates the two DRIVE_TIMING_ERROR cases
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fc_r <= 16'h0000;
            fc_moved_r <= 1'b0;
        end else if (i_fc_load_en) begin
            fc_r <= i_fc_load;
            fc_moved_r <= 1'b0;
        end else if (i_frame_step && !eob_r) begin
            fc_r <= fc_r + 16'h0001;
            fc_moved_r <= 1'b1;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            eob_r <= 1'b0;
        end else if (i_cmd_start) begin
            eob_r <= 1'b0;
        end else if (dte_set || i_xfer_end || i_space_end) begin
            eob_r <= 1'b1;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lrc_r <= 8'h00;
        end else if (i_cmd_start || i_lrc_valid) begin
            lrc_r <= 8'h00;
        end else if (i_rd_char) begin
            lrc_r <= lrc_r ^ i_rd_data;
        end
    end
    // Early-gap characters are held until the next command start or a clear
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gap_char_r <= 1'b0;
        end else if (i_rd_char && i_gap_first_half) begin
            gap_char_r <= 1'b1;
        end else if (i_cmd_start || clr) begin
            gap_char_r <= 1'b0;
        end
    end
    // Filemark hunt: char, seven blanks, char
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fm_st_r <= FM_IDLE;
            blank_r <= 3'h0;
            fm_char_r <= 8'h00;
        end else if (i_rd_char) begin
            fm_st_r <= (fm_st_r == FM_SECOND) ? FM_IDLE : FM_BLANKS;
            fm_char_r <= i_rd_data;
            blank_r <= 3'h0;
        end else if (i_blank_char) begin
            unique case (fm_st_r)
                FM_IDLE: begin
                    fm_st_r <= FM_IDLE;
                end
                FM_BLANKS: begin
                    blank_r <= blank_r + 3'h1;
                    if (blank_r + 3'h1 == tfe_pkg::FM_BLANK_GAP) begin
                        fm_st_r <= FM_SECOND;
                    end
                end
                FM_SECOND: begin
                    fm_st_r <= FM_IDLE;
                end
                default: begin
                    fm_st_r <= FM_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tm_r <= 1'b0;
        end else if (fm_bad) begin
            tm_r <= 1'b1;
        end else if (clr || i_cmd_start) begin
            tm_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    wire [15:0] rd_mux = (i_addr == tfe_pkg::ADDR_ERR_FLAGS) ? err_r :
        (i_addr == tfe_pkg::ADDR_CTRL) ? ctrl_r : 16'h0000;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= i_rd ? rd_mux : 16'h0000;
        end
    end
    assign o_rdata = rdata_r;
    assign o_end_of_block = eob_r;
    assign o_exception = eob_r & err_r[tfe_pkg::BIT_DTE];
    assign o_abort = eob_r & err_r[tfe_pkg::BIT_DTE];
    assign o_tape_mark = tm_r;
    assign o_frame_count = fc_r;
    ////////////////////////////////////////////////////////////////////////////
    sequence s_dte_cause;
        dte_set;
    endsequence
    a_dte_sets_eob: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_dte_cause ##1 1'b1 |-> o_end_of_block && o_exception && o_abort)
        else $error("timing error without end of block");
    a_dte_flag_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        occ_err |=> err_r[tfe_pkg::BIT_DTE]) else $error("occupied transfer missed");
    a_read_no_late: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_cmd_write |-> !late_wclk) else $error("late clock on read");
    a_late_moved_fc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_frame_step && !eob_r && !i_fc_load_en |=> fc_moved_r) else $error("frame count not moved");
    a_nef_protect: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_start && i_cmd_write && i_write_protect |=> err_r[tfe_pkg::BIT_NEF]) else $error("nef missed");
    a_nef_bot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_start && i_cmd_reverse && i_bot |=> err_r[tfe_pkg::BIT_NEF]) else $error("nef bot missed");
    a_fce_run: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        eob_r && i_run |=> err_r[tfe_pkg::BIT_FCE]) else $error("run held not flagged");
    a_flags_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !clr && $past(!clr) |-> (err_r & $past(err_r)) == $past(err_r)) else $error("flag dropped");
    a_bad_fm_both: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        fm_bad |=> o_tape_mark && err_r[tfe_pkg::BIT_SKEW]) else $error("bad filemark flags");
    a_write_noeff: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_wr && !clr && err_nxt == err_r |=> err_r == $past(err_r)) else $error("write changed flags");
    ////////////////////////////////////////////////////////////////////////////
    // Per-flag checks, plus frame-count, clear, spare-bit and idle-read checks
    a_late_sets_dte: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        late_wclk |=> err_r[tfe_pkg::BIT_DTE])
        else $error("late clock missed");
    a_late_needs_move: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        late_wclk |-> fc_moved_r)
        else $error("late clock before first frame");
    a_dte_freeze_fc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        eob_r && err_r[tfe_pkg::BIT_DTE] && !i_fc_load_en |=> o_frame_count == $past(o_frame_count))
        else $error("frame count moved after abort");
    a_nef_density: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_start && (den2 != i_pe_capable) |=> err_r[tfe_pkg::BIT_NEF])
        else $error("density mismatch missed");
    a_nef_fcs: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_start && (i_cmd_space || i_cmd_write) && !frame_count_status_bit |=> err_r[tfe_pkg::BIT_NEF])
        else $error("frame status refusal missed");
    a_nef_short: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_start && (i_cmd_read || i_cmd_write) && !den2 && (fc_neg < tfe_pkg::MIN_FRAMES)
        |=> err_r[tfe_pkg::BIT_NEF])
        else $error("short record missed");
    a_skew_warn: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        den2 && i_pe_skew_warn |=> err_r[tfe_pkg::BIT_SKEW])
        else $error("skew warning missed");
    sequence s_fm_first;
        i_rd_char && !den2 && fm_st_r != FM_SECOND;
    endsequence
    sequence s_fm_blanks;
        (i_blank_char && !i_rd_char) [*7];
    endsequence
    sequence s_fm_second;
        i_rd_char && !den2 && !(i_rd_data == tfe_pkg::FM_CHAR && fm_char_r == tfe_pkg::FM_CHAR);
    endsequence
    a_fm_pattern: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_fm_first ##1 s_fm_blanks ##1 s_fm_second |=> err_r[tfe_pkg::BIT_SKEW])
        else $error("bad filemark not flagged");
    a_fce_space: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_space_end && fc_r != 16'h0000 |=> err_r[tfe_pkg::BIT_FCE])
        else $error("space count error missed");
    a_nsg_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_xfer_end && gap_char_r |=> err_r[tfe_pkg::BIT_NSG])
        else $error("gap flag missed");
    a_pe_format: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        den2 && i_pe_bad_amble |=> err_r[tfe_pkg::BIT_FMT])
        else $error("format error missed");
    a_lrc_check: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !den2 && i_lrc_valid && i_lrc_tape != lrc_r |=> err_r[tfe_pkg::BIT_FMT])
        else $error("lrc mismatch missed");
    a_pe_incorr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_read && den2 && (i_pe_multi_dead || i_pe_parity_nodead || i_pe_skew_ovf)
        |=> err_r[tfe_pkg::BIT_INC])
        else $error("incorrectable data missed");
    a_nrz_parity: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cmd_read && !den2 && (i_nrz_parity_err || i_nrz_late_data) |=> err_r[tfe_pkg::BIT_INC])
        else $error("parity error missed");
    a_clear_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        clr && !(dte_set || nef_set || skew_set || fce_set || nsg_set || fmt_set || inc_set)
        |=> err_r == tfe_pkg::ERR_RESET)
        else $error("clear left flags");
    a_spare_bits: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (err_r & 16'hE03F) == 16'h0000)
        else $error("bit outside block set");
    a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data without read");
endmodule

// File: verilog/tfe_pkg.sv
package tfe_pkg;
    localparam logic [4:0] ADDR_ERR_FLAGS = 5'h02;
    localparam logic [4:0] ADDR_CTRL = 5'h03;
    localparam logic [15:0] ERR_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int BIT_DTE = 12;
    localparam int BIT_NEF = 11;
    localparam int BIT_SKEW = 10;
    localparam int BIT_FCE = 9;
    localparam int BIT_NSG = 8;
    localparam int BIT_FMT = 7;
    localparam int BIT_INC = 6;
    localparam int CTRL_DEN2 = 0;
    localparam int CTRL_FCS = 1;
    localparam logic [15:0] MIN_FRAMES = 16'h000D;
    localparam logic [2:0] FM_BLANK_GAP = 3'h7;
    localparam logic [7:0] FM_CHAR = 8'h13;
endpackage

// File: verif/tfe_host_model.sv
`timescale 1ns/10ps
module tfe_host_model (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_slow,
    input wire logic i_stick,
    input wire logic i_cmd_start,
    input wire logic i_end_of_block,
    output logic o_wclk,
    output logic o_run
);
    logic run_r;
    // Slow host withholds write clock; stuck host ignores end of block
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wclk <= 1'b0;
            run_r <= 1'b0;
        end else begin
            o_wclk <= i_slow ? 1'b0 : ~o_wclk;
            if (i_cmd_start) begin
                run_r <= 1'b1;
            end else if (i_end_of_block && !i_stick) begin
                run_r <= 1'b0;
            end
        end
    end
    // Prompt host drops run in the very cycle end of block shows
    assign o_run = run_r & ~(i_end_of_block & ~i_stick);
endmodule

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [15:0] i_wdata = 16'h0000, i_fc_load = 16'h0000, rd_val, o_rdata, o_frame_count;
    logic [7:0] i_rd_data = 8'h00, i_lrc_tape = 8'h00;
    logic i_cmd_write = 1'b0, i_cmd_space = 1'b0, i_cmd_reverse = 1'b0, i_bus_occupied = 1'b0;
    logic i_write_protect = 1'b0, i_bot = 1'b0, i_pe_capable = 1'b0, i_gap_first_half = 1'b0;
    logic i_blank_char = 1'b0, i_lrc_valid = 1'b0, i_frame_step = 1'b0, slow = 1'b0, stick = 1'b0;
    logic o_end_of_block, o_exception, o_abort, o_tape_mark;
    logic [16:0] ev = 17'h00000;
    wire i_wclk, i_run;
    wire i_cmd_read = !(i_cmd_write | i_cmd_space);
    wire i_cmd_start = ev[0], i_xfer_start = ev[1], i_space_end = ev[2], i_xfer_end = ev[3],
        i_char_due = ev[4], i_rd_char = ev[5], i_pe_skew_warn = ev[6], i_pe_bad_amble = ev[7],
        i_pe_multi_dead = ev[8], i_pe_parity_nodead = ev[9], i_pe_skew_ovf = ev[10],
        i_nrz_parity_err = ev[11], i_nrz_late_data = ev[12], i_drive_clear = ev[13],
        i_bus_init = ev[14], i_fc_load_en = ev[15];
    int errors = 0;
    int total_checks = 0;

    tfe_error_flags uut (.*);
    tfe_host_model host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(slow), .i_stick(stick),
        .i_cmd_start(i_cmd_start), .i_end_of_block(o_end_of_block), .o_wclk(i_wclk), .o_run(i_run));

    always #25 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask
    // Index 16 is a spare strobe, a no-op stimulus
    task automatic fire(input int k);
        @(posedge i_clk);
        ev[k] <= 1'b1;
        i_rd_data <= 8'($urandom);
        @(posedge i_clk);
        ev <= '0;
    endtask
    function automatic logic [15:0] exp_flags(input int n);
        case (n)
            0, 12: return 16'h0001 << tfe_pkg::BIT_DTE;
            1, 2, 3, 4, 5: return 16'h0001 << tfe_pkg::BIT_NEF;
            6, 15: return 16'h0001 << tfe_pkg::BIT_SKEW;
            7, 14: return 16'h0001 << tfe_pkg::BIT_FCE;
            8: return 16'h0001 << tfe_pkg::BIT_NSG;
            9, 16: return 16'h0001 << tfe_pkg::BIT_FMT;
            10, 11: return 16'h0001 << tfe_pkg::BIT_INC;
            default: return tfe_pkg::ERR_RESET;
        endcase
    endfunction
    function automatic int stim(input int n);
        case (n)
            6: return 6;
            7: return 2;
            8, 14: return 3;
            9: return 7;
            10: return 8 + $urandom_range(0, 2);
            11: return 11 + $urandom_range(0, 1);
            12, 13: return 4;
            default: return 16;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Baseline keeps every other refusal quiet: FRAME_COUNT_STATUS_BIT set, count of 20 frames
    task automatic run_case(input int n);
        reg_wr(tfe_pkg::ADDR_CTRL, (n == 4) ? 16'h0000 : ((n inside {3, 6, 9, 10}) ? 16'h0003 : 16'h0002));
        i_fc_load <= (n == 5) ? 16'hFFF4 : 16'hFFEC;
        fire(15);
        i_pe_capable <= n inside {6, 9, 10};
        i_bus_occupied <= (n == 0);
        i_write_protect <= (n == 1);
        i_bot <= (n == 2);
        i_cmd_reverse <= (n == 2);
        i_cmd_write <= n inside {1, 12};
        i_cmd_space <= n inside {4, 7};
        slow <= n inside {12, 13};
        stick <= (n == 14);
        fire(0);
        fire(1);
        if (n == 8) begin
            i_gap_first_half <= 1'b1;
            fire(5);
            i_gap_first_half <= 1'b0;
        end
        if (n == 12) begin
            i_frame_step <= 1'b1;
            @(posedge i_clk);
            i_frame_step <= 1'b0;
        end
        if (n == 15) begin
            fire(5);
            i_blank_char <= 1'b1;
            repeat (7) @(posedge i_clk);
            i_blank_char <= 1'b0;
            i_rd_data <= 8'h00;
            ev[5] <= 1'b1;
            @(posedge i_clk);
            ev <= '0;
        end
        if (n == 16) begin
            fire(5);
            i_lrc_tape <= ~i_rd_data;
            i_lrc_valid <= 1'b1;
            @(posedge i_clk);
            i_lrc_valid <= 1'b0;
        end
        fire(stim(n));
        repeat (3) @(posedge i_clk);
        reg_rd(tfe_pkg::ADDR_ERR_FLAGS);
        chk(rd_val, exp_flags(n));
        if (n == 12) begin
            chk(o_frame_count, 16'hFFED);
        end
        if (n == 15) begin
            chk({15'h0000, o_tape_mark}, 16'h0001);
        end
        if (n == 0) begin
            chk({13'h0000, o_end_of_block, o_exception, o_abort}, 16'h0007);
            chk(o_frame_count, 16'hFFEC);
        end
        reg_wr(tfe_pkg::ADDR_ERR_FLAGS, 16'($urandom));
        repeat ($urandom_range(1, 4)) @(posedge i_clk);
        reg_rd(tfe_pkg::ADDR_ERR_FLAGS);
        chk(rd_val, exp_flags(n));
        stick <= 1'b0;
        fire(n[0] ? 13 : 14);
        reg_rd(tfe_pkg::ADDR_ERR_FLAGS);
        chk(rd_val, tfe_pkg::ERR_RESET);
        $display("test %0d done", n);
    endtask

    initial begin
        void'($urandom(32'h8AA0));
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        reg_rd(tfe_pkg::ADDR_ERR_FLAGS);
        chk(rd_val, tfe_pkg::ERR_RESET);
        reg_rd(5'h1F);
        chk(rd_val, 16'h0000);
        for (int n = 0; n < 17; n++) begin
            run_case(n);
        end
        finish_test();
    end
    // Whole run is about 450 cycles; this is ample headroom
    initial begin
        #1000000;
        errors++;
        finish_test();
    end
endmodule
